// ---- rtl/cpi_ctl.sv ----
// eight-level priority interrupt controller core with command port
`timescale 1ns/100ps
module cpi_ctl
(
   input wire logic CORE_CLK_IN,
   input wire logic RESET_IN,
   input wire logic ADDR_IN,
   input wire logic [7:0] WR_DATA_IN,
   input wire logic WR_STB_IN,
   input wire logic RD_STB_IN,
   output logic [7:0] RD_DATA_OUT,
   input wire logic [7:0] REQ_IN,
   output logic INT_OUT,
   input wire logic ACK_IN,
   output logic [7:0] VEC_OUT,
   output logic VEC_VALID_OUT,
   output logic [7:0] CASC_OUT
);
   import cpi_pkg::*;

   cpi_regs_t s_q;
   cpi_regs_t s_d;
   cpi_res_if rif ();

   assign rif.req = s_q.pend & ~s_q.mask;
   assign rif.in_service_reg = s_q.in_service_reg;
   assign rif.low = s_q.low;
   assign rif.smm = s_q.smm;

   cpi_resolver u_res
   (
      .rif(rif)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic [7:0] req_set;
      logic [7:0] pend_clr;
      logic [7:0] isr_set;
      logic [7:0] isr_clr;
      logic [2:0] lvl;
      logic wr_cmd;
      logic wr_data;
      req_set = s_q.edge_mode ? (REQ_IN & ~s_q.req_prev) : REQ_IN;
      pend_clr = BYTE_ZERO;
      isr_set = BYTE_ZERO;
      isr_clr = BYTE_ZERO;
      lvl = WR_DATA_IN[2:0];
      wr_cmd = WR_STB_IN && (ADDR_IN == PORT_CMD);
      wr_data = WR_STB_IN && (ADDR_IN == PORT_DATA);
      s_d = s_q;
      s_d.vec_valid = 1'b0;
      s_d.rd_data = BYTE_ZERO;
      s_d.req_prev = REQ_IN;
      // acknowledge moves the winner into service unless automatic end is set
      if (ACK_IN && s_q.st == ST_READY)
      begin
         s_d.vec_valid = 1'b1;
         if (rif.win_valid)
         begin
            pend_clr = 8'h01 << rif.win_lvl;
            s_d.vec = {s_q.vec_hi, rif.win_lvl};
            if (!s_q.auto_end)
            begin
               isr_set = 8'h01 << rif.win_lvl;
            end
            else if (s_q.rot_aeoi)
            begin
               s_d.low = rif.win_lvl;
            end
         end
         else
         begin
            s_d.vec = {s_q.vec_hi, SPURIOUS_LVL};
         end
      end
      // setup sequence and operation words
      unique case (s_q.st)
         ST_VEC:
         begin
            if (wr_data)
            begin
               s_d.vec_hi = WR_DATA_IN[7:IWV_HI_LSB];
               s_d.st = !s_q.single ? ST_CASC : (s_q.need_mode ? ST_MODE : ST_READY);
            end
         end
         ST_CASC:
         begin
            if (wr_data)
            begin
               s_d.casc = WR_DATA_IN;
               s_d.st = s_q.need_mode ? ST_MODE : ST_READY;
            end
         end
         ST_MODE:
         begin
            if (wr_data)
            begin
               s_d.auto_end = WR_DATA_IN[IWM_AUTO_END_BIT];
               s_d.st = ST_READY;
            end
         end
         ST_READY:
         begin
            if (wr_data)
            begin
               s_d.mask = WR_DATA_IN;
            end
            else if (wr_cmd && WR_DATA_IN[OPW_THIRD_BIT])
            begin
               if (WR_DATA_IN[OPW_RD_ACT_BIT])
               begin
                  s_d.sel_isr = WR_DATA_IN[OPW_RD_SEL_BIT];
               end
               if (WR_DATA_IN[OPW_SMM_ACT_BIT])
               begin
                  s_d.smm = WR_DATA_IN[OPW_SMM_VAL_BIT];
               end
            end
            else if (wr_cmd && !WR_DATA_IN[IW1_ID_BIT])
            begin
               unique case (WR_DATA_IN[7:OPW_CMD_LSB])
                  PRI_NS_EOI:
                  begin
                     if (rif.top_valid)
                     begin
                        isr_clr = 8'h01 << rif.top_lvl;
                        if (s_q.auto_rot)
                        begin
                           s_d.low = rif.top_lvl;
                        end
                     end
                  end
                  PRI_ROT_NS_EOI:
                  begin
                     s_d.auto_rot = 1'b1;
                     s_d.spec_rot = 1'b0;
                     if (rif.top_valid)
                     begin
                        isr_clr = 8'h01 << rif.top_lvl;
                        s_d.low = rif.top_lvl;
                     end
                  end
                  PRI_SP_EOI:
                  begin
                     isr_clr = 8'h01 << lvl;
                  end
                  PRI_ROT_SP_EOI:
                  begin
                     isr_clr = 8'h01 << lvl;
                     s_d.low = lvl;
                     s_d.spec_rot = 1'b1;
                     s_d.auto_rot = 1'b0;
                  end
                  PRI_SET_LOW:
                  begin
                     s_d.low = lvl;
                  end
                  PRI_ROT_AEOI_SET:
                  begin
                     s_d.rot_aeoi = 1'b1;
                  end
                  PRI_ROT_AEOI_CLR:
                  begin
                     s_d.rot_aeoi = 1'b0;
                  end
                  PRI_NOP:
                  begin
                  end
               endcase
            end
         end
         ST_UNINIT:
         begin
         end
      endcase
      s_d.in_service_reg = (s_q.in_service_reg & ~isr_clr) | isr_set;
      // set wins over clear for pending bits
      s_d.pend = s_q.edge_mode ? ((s_q.pend & ~pend_clr) | req_set) : REQ_IN;
      // first word restarts setup from any state
      if (wr_cmd && WR_DATA_IN[IW1_ID_BIT])
      begin
         s_d.st = ST_VEC;
         s_d.edge_mode = WR_DATA_IN[IW1_EDGE_BIT];
         s_d.single = WR_DATA_IN[IW1_SINGLE_BIT];
         s_d.need_mode = WR_DATA_IN[IW1_NEED_MODE_BIT];
         s_d.mask = MASK_RST;
         s_d.in_service_reg = BYTE_ZERO;
         s_d.pend = BYTE_ZERO;
         s_d.low = LOW_RST;
         s_d.auto_end = 1'b0;
         s_d.auto_rot = 1'b0;
         s_d.spec_rot = 1'b0;
         s_d.rot_aeoi = 1'b0;
         s_d.smm = 1'b0;
         s_d.sel_isr = 1'b0;
         s_d.vec_valid = 1'b0;
      end
      if (RD_STB_IN)
      begin
         if (ADDR_IN == PORT_DATA)
         begin
            s_d.rd_data = s_q.mask;
         end
         else
         begin
            s_d.rd_data = s_q.sel_isr ? s_q.in_service_reg : s_q.pend;
         end
      end
      s_d.irq = rif.win_valid && (s_q.st == ST_READY);
   end

   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         s_q <= '{st: ST_UNINIT, low: LOW_RST, mask: MASK_RST, default: '0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign RD_DATA_OUT = s_q.rd_data;
   assign INT_OUT = s_q.irq;
   assign VEC_OUT = s_q.vec;
   assign VEC_VALID_OUT = s_q.vec_valid;
   assign CASC_OUT = s_q.casc;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (RESET_IN);

   logic ready;
   assign ready = (s_q.st == ST_READY);

   sequence s_cmd(logic [7:0] v);
      ready && WR_STB_IN && ADDR_IN == PORT_CMD && WR_DATA_IN == v;
   endsequence
   sequence s_pri(logic [7:0] v);
      ready && WR_STB_IN && ADDR_IN == PORT_CMD && WR_DATA_IN[7:3] == v[7:3] && !ACK_IN;
   endsequence

   AST_NESTED_AFTER_SETUP: assert property ($rose(ready) |-> !s_q.auto_rot && !s_q.spec_rot
      && !s_q.smm) else $error("controller left setup not in nested mode");
   AST_ROT_SELECT: assert property (s_cmd(CMD_ROT_EOI) |=> s_q.auto_rot && !s_q.spec_rot)
      else $error("rotate on end command did not select auto rotation");
   AST_NS_EOI: assert property ((s_cmd(CMD_EOI) ##0 (rif.top_valid && !ACK_IN))
      |=> s_q.in_service_reg == ($past(s_q.in_service_reg) & ~(8'h01 << $past(rif.top_lvl))))
      else $error("nonspecific end did not clear top in-service bit");
   AST_ROT_SPEC: assert property (s_pri(8'hE0) |=> !s_q.in_service_reg[s_q.low]
      && s_q.low == $past(WR_DATA_IN[2:0]) && s_q.spec_rot)
      else $error("rotate specific end wrong");
   AST_SPEC_EOI: assert property (s_pri(8'h60) |=> s_q.in_service_reg ==
      ($past(s_q.in_service_reg) & ~(8'h01 << $past(WR_DATA_IN[2:0])))) else $error("specific end wrong");
   AST_SET_LOW: assert property (s_pri(8'hC0) |=> s_q.in_service_reg == $past(s_q.in_service_reg)
      && s_q.low == $past(WR_DATA_IN[2:0])) else $error("priority set changed in-service");
   AST_READ_PEND: assert property (s_cmd(CMD_READ_PEND) ##1 (RD_STB_IN && ADDR_IN == PORT_CMD)
      |=> RD_DATA_OUT == $past(s_q.pend)) else $error("pending status read wrong");
   AST_READ_INSV: assert property (s_cmd(CMD_READ_INSV) ##1 (RD_STB_IN && ADDR_IN == PORT_CMD)
      |=> RD_DATA_OUT == $past(s_q.in_service_reg)) else $error("in-service status read wrong");
   AST_MASK: assert property (ready && WR_STB_IN && ADDR_IN == PORT_DATA
      |=> s_q.mask == $past(WR_DATA_IN) ##1 1'b1) else $error("mask write lost");
   AST_SMM: assert property (s_cmd(CMD_SMM_SET) |=> s_q.smm)
      else $error("special mask not set");
   AST_SMM_CLEAR: assert property (s_cmd(8'h48) |=> !s_q.smm)
      else $error("special mask not cleared");
   AST_ROT_AEOI: assert property (s_cmd(8'h80) |=> s_q.rot_aeoi)
      else $error("rotate in auto end not set");
   AST_MASK_REFUSED: assert property (!ready && WR_STB_IN && ADDR_IN == PORT_DATA
      |=> s_q.mask == $past(s_q.mask)) else $error("mask changed before setup done");
   AST_EDGE_PEND: assert property (s_q.edge_mode && !WR_STB_IN && !ACK_IN
      |=> s_q.pend == ($past(s_q.pend) | ($past(REQ_IN) & ~$past(REQ_IN, 2))))
      else $error("edge request capture wrong");
   AST_RESTART: assert property (WR_STB_IN && ADDR_IN == PORT_CMD && WR_DATA_IN[IW1_ID_BIT]
      |=> s_q.st == ST_VEC && s_q.mask == MASK_RST && s_q.edge_mode == $past(WR_DATA_IN[3]))
      else $error("first setup word did not restart");
endmodule

// ---- inc/cpi_pkg.sv ----
// constants, state codes and state record of the priority interrupt controller
package cpi_pkg;
   localparam int NUM_LEVELS = 8;
   localparam int LVL_W = 3;
   // port select on the address line
   localparam logic PORT_CMD = 1'b0;
   localparam logic PORT_DATA = 1'b1;
   // init_word_one fields
   localparam int IW1_ID_BIT = 4;
   localparam int IW1_NEED_MODE_BIT = 0;
   localparam int IW1_SINGLE_BIT = 1;
   localparam int IW1_EDGE_BIT = 3;
   // init_word_vector and init_word_mode fields
   localparam int IWV_HI_LSB = 3;
   localparam int IWM_AUTO_END_BIT = 1;
   // operation word selection and fields
   localparam int OPW_THIRD_BIT = 3;
   localparam int OPW_CMD_LSB = 5;
   localparam int OPW_RD_ACT_BIT = 1;
   localparam int OPW_RD_SEL_BIT = 0;
   localparam int OPW_SMM_ACT_BIT = 6;
   localparam int OPW_SMM_VAL_BIT = 5;
   // op_word_priority command field, bits 7..5
   localparam logic [2:0] PRI_ROT_AEOI_CLR = 3'h0;
   localparam logic [2:0] PRI_NS_EOI = 3'h1;
   localparam logic [2:0] PRI_NOP = 3'h2;
   localparam logic [2:0] PRI_SP_EOI = 3'h3;
   localparam logic [2:0] PRI_ROT_AEOI_SET = 3'h4;
   localparam logic [2:0] PRI_ROT_NS_EOI = 3'h5;
   localparam logic [2:0] PRI_SET_LOW = 3'h6;
   localparam logic [2:0] PRI_ROT_SP_EOI = 3'h7;
   // whole command bytes
   localparam logic [7:0] CMD_EOI = 8'h20;
   localparam logic [7:0] CMD_ROT_EOI = 8'hA0;
   localparam logic [7:0] CMD_READ_PEND = 8'h0A;
   localparam logic [7:0] CMD_READ_INSV = 8'h0B;
   localparam logic [7:0] CMD_SMM_SET = 8'h68;
   // values after reset or restart, and the level given on an acknowledge with no winner
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [2:0] LOW_RST = 3'h7;
   localparam logic [2:0] SPURIOUS_LVL = 3'h7;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   typedef enum logic [4:0] {
      ST_UNINIT = 5'h01,
      ST_VEC = 5'h02,
      ST_CASC = 5'h04,
      ST_MODE = 5'h08,
      ST_READY = 5'h10
   } cpi_state_e_t;

   typedef struct packed {
      cpi_state_e_t st;
      logic [7:0] pend;
      logic [7:0] in_service_reg;
      logic [7:0] mask;
      logic [7:0] req_prev;
      logic [2:0] low;
      logic [4:0] vec_hi;
      logic [7:0] casc;
      logic edge_mode;
      logic single;
      logic need_mode;
      logic auto_end;
      logic auto_rot;
      logic spec_rot;
      logic rot_aeoi;
      logic smm;
      logic sel_isr;
      logic irq;
      logic [7:0] vec;
      logic vec_valid;
      logic [7:0] rd_data;
   } cpi_regs_t;
endpackage

// ---- inc/cpi_res_if.sv ----
// link between the controller core and its priority resolver
`timescale 1ns/100ps
interface cpi_res_if;
   logic [7:0] req;
   logic [7:0] in_service_reg;
   logic [2:0] low;
   logic smm;
   logic win_valid;
   logic [2:0] win_lvl;
   logic top_valid;
   logic [2:0] top_lvl;
   modport ctl (output req, output in_service_reg, output low, output smm,
      input win_valid, input win_lvl, input top_valid, input top_lvl);
   modport res (input req, input in_service_reg, input low, input smm,
      output win_valid, output win_lvl, output top_valid, output top_lvl);
endinterface

// ---- rtl/cpi_resolver.sv ----
// rotating priority resolver for eight request levels
`timescale 1ns/100ps
module cpi_resolver
(
   cpi_res_if.res rif
);
   import cpi_pkg::*;

   always_comb
   begin
      logic [2:0] lvl;
      logic stop;
      logic tstop;
      lvl = 3'h0;
      stop = 1'b0;
      tstop = 1'b0;
      rif.win_valid = 1'b0;
      rif.win_lvl = 3'h0;
      rif.top_valid = 1'b0;
      rif.top_lvl = 3'h0;
      // scan from the level just above the lowest one
      for (int i = 0; i < NUM_LEVELS; i++)
      begin
         lvl = 3'(rif.low + 3'(i) + 3'h1);
         if (!tstop && rif.in_service_reg[lvl])
         begin
            rif.top_valid = 1'b1;
            rif.top_lvl = lvl;
            tstop = 1'b1;
         end
         if (!stop)
         begin
            if (rif.req[lvl] && !rif.in_service_reg[lvl])
            begin
               rif.win_valid = 1'b1;
               rif.win_lvl = lvl;
               stop = 1'b1;
            end
            else if (rif.in_service_reg[lvl] && !rif.smm)
            begin
               // in-service level blocks itself and all below it
               stop = 1'b1;
            end
         end
      end
   end
endmodule

// ---- testbench/cpi_host_model.sv ----
// host side model: port writes, reads and acknowledges
`timescale 1ns/100ps
module cpi_host_model
   import cpi_pkg::*;
(
   input wire logic clk_in,
   output logic addr_out,
   output logic [7:0] wd_out,
   output logic wr_out,
   output logic rd_out,
   output logic ack_out,
   input wire logic [7:0] rd_in,
   input wire logic [7:0] vec_in,
   input wire logic vld_in
);
   logic inited;
   task automatic idle();
      inited = 1'b0;
      addr_out <= 1'b0;
      wd_out <= 8'h00;
      wr_out <= 1'b0;
      rd_out <= 1'b0;
      ack_out <= 1'b0;
   endtask
   // status select then read with no gap between the strobes
   task automatic wr_rd(input logic [7:0] c, input logic a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= PORT_CMD;
      wd_out <= c;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      wd_out <= ~c;
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      #1;
      d = rd_in;
   endtask
   task automatic wr(input logic a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wd_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      wd_out <= ~d;
   endtask
   task automatic rd(input logic a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      #1;
      d = rd_in;
   endtask
   task automatic ack(output logic [7:0] v, output logic vld);
      @(posedge clk_in);
      ack_out <= inited;
      @(posedge clk_in);
      ack_out <= 1'b0;
      #1;
      v = vec_in;
      vld = vld_in;
   endtask
   // first word on command port, the rest on the data port in order
   task automatic init_ctl(input logic [7:0] v, input logic [7:0] c, input logic [7:0] m);
      inited = 1'b0;
      wr(PORT_CMD, 8'h11);
      wr(PORT_DATA, v);
      wr(PORT_DATA, c);
      wr(PORT_DATA, m);
      inited = 1'b1;
   endtask
endmodule

// ---- testbench/cpi_ctl_tb.sv ----
// self-checking bench of the priority interrupt controller
`timescale 1ns/100ps
module cpi_ctl_tb;
   import cpi_pkg::*;
   logic clk, rst, addr, wr, rd, ack, int_o, vv_o;
   logic [7:0] wd, rdo, req, vec_o, casc, r, v;
   logic vv;
   int err_total = 0;
   int comparisons = 0;
   cpi_ctl cpi_ctl_inst (.CORE_CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr),
      .WR_DATA_IN(wd), .WR_STB_IN(wr), .RD_STB_IN(rd), .RD_DATA_OUT(rdo),
      .REQ_IN(req), .INT_OUT(int_o), .ACK_IN(ack), .VEC_OUT(vec_o),
      .VEC_VALID_OUT(vv_o), .CASC_OUT(casc));
   cpi_host_model cpi_host_model_inst (.clk_in(clk), .addr_out(addr), .wd_out(wd),
      .wr_out(wr), .rd_out(rd), .ack_out(ack), .rd_in(rdo), .vec_in(vec_o),
      .vld_in(vv_o));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] d);
      cpi_host_model_inst.wr(PORT_CMD, d);
   endtask
   // bounded wait for the request line, then acknowledge and compare vector
   task automatic serve(input logic [7:0] exp);
      int n;
      n = 0;
      while (int_o !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (int_o !== 1'b1)
      begin
         check({7'h00, int_o}, 8'h01);
         test_done();
      end
      cpi_host_model_inst.ack(v, vv);
      check(v, exp);
      check({7'h00, vv}, 8'h01);
   endtask
   task automatic no_int();
      repeat (4) @(posedge clk);
      #1;
      check({7'h00, int_o}, 8'h00);
   endtask
   task automatic rd_isr(input logic [7:0] exp);
      cpi_host_model_inst.wr_rd(CMD_READ_INSV, PORT_CMD, r);
      check(r, exp);
   endtask
   task automatic t_master();
      cpi_host_model_inst.init_ctl(8'h08, 8'h01, 8'h1D);
      check(casc, 8'h01);
      cpi_host_model_inst.wr(PORT_DATA, 8'hFF);
      cpi_host_model_inst.rd(PORT_DATA, r);
      check(r, 8'hFF);
      req <= 8'h08;
      cpi_host_model_inst.wr_rd(CMD_READ_PEND, PORT_CMD, r);
      check(r, 8'h08);
      no_int();
      cpi_host_model_inst.wr(PORT_DATA, 8'hF7);
      serve(8'h0B);
      rd_isr(8'h08);
      req <= 8'h00;
      cmd(CMD_EOI);
      rd_isr(8'h00);
      $display("test master setup done");
   endtask
   task automatic t_nested();
      cpi_host_model_inst.wr(PORT_DATA, 8'h00);
      req <= 8'h24;
      serve(8'h0A);
      no_int();
      req <= 8'h20;
      cmd(8'h62);
      serve(8'h0D);
      rd_isr(8'h20);
      req <= 8'h00;
      cmd(CMD_EOI);
      rd_isr(8'h00);
      $display("test nested done");
   endtask
   task automatic t_rotate();
      req <= 8'h08;
      cmd(CMD_ROT_EOI);
      serve(8'h0B);
      req <= 8'h11;
      cmd(CMD_EOI);
      serve(8'h0C);
      cmd(8'hE4);
      serve(8'h08);
      rd_isr(8'h01);
      cmd(8'hC3);
      serve(8'h0C);
      rd_isr(8'h11);
      req <= 8'h00;
      cmd(8'h64);
      cmd(8'h60);
      rd_isr(8'h00);
      $display("test rotate done");
   endtask
   task automatic t_restart();
      cmd(8'h11);
      cpi_host_model_inst.wr(PORT_DATA, 8'h50);
      cmd(CMD_READ_INSV);
      cpi_host_model_inst.init_ctl(8'h10, 8'h00, 8'h19);
      check(casc, 8'h00);
      cpi_host_model_inst.rd(PORT_DATA, r);
      check(r, MASK_RST);
      cpi_host_model_inst.rd(PORT_CMD, r);
      check(r, 8'h00);
      $display("test restart done");
   endtask
   task automatic t_smm();
      req <= 8'h02;
      serve(8'h11);
      req <= 8'h22;
      no_int();
      cmd(CMD_SMM_SET);
      serve(8'h15);
      rd_isr(8'h22);
      cmd(8'h48);
      req <= 8'h00;
      cmd(8'h65);
      cmd(8'h61);
      rd_isr(8'h00);
      $display("test special mask done");
   endtask
   // single controller, edge requests, automatic end and its rotation
   task automatic t_edge();
      cmd(8'h1B);
      cpi_host_model_inst.wr(PORT_DATA, 8'h18);
      cpi_host_model_inst.wr(PORT_DATA, 8'h03);
      cpi_host_model_inst.rd(PORT_DATA, r);
      check(r, MASK_RST);
      req <= 8'h04;
      serve(8'h1A);
      no_int();
      rd_isr(8'h00);
      cmd(8'h80);
      cmd(8'h40);
      req <= 8'h05;
      serve(8'h18);
      req <= 8'h00;
      no_int();
      req <= 8'h03;
      serve(8'h19);
      serve(8'h18);
      cmd(8'h00);
      req <= 8'h00;
      no_int();
      req <= 8'h02;
      serve(8'h19);
      req <= 8'h00;
      no_int();
      req <= 8'h03;
      serve(8'h19);
      serve(8'h18);
      req <= 8'h00;
      $display("test edge and auto end done");
   endtask
   initial
   begin
      rst <= 1'b1;
      req <= 8'h00;
      cpi_host_model_inst.idle();
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      #1;
      check({int_o, vv_o, 6'h00}, 8'h00);
      check(casc, 8'h00);
      check(rdo | vec_o, 8'h00);
      t_master();
      t_nested();
      t_rotate();
      t_restart();
      t_smm();
      t_edge();
      test_done();
   end
endmodule
